/* File: csm_assertions.sv */
// Checker of bus answers and pin timing for the serial channel.
`timescale 1ns/1ps
module csm_assertions
  import csm_pkg::*;
(
  input wire logic               hclk,      // Clock.
  input wire logic               hresetn,   // Reset, active low.
  input wire logic               hsel,      // Select.
  input wire logic [31:0]        haddr,     // Address.
  input wire logic [1:0]         htrans,    // Transfer type.
  input wire logic               hwrite,    // Write.
  input wire logic [2:0]         hsize,     // Size.
  input wire logic               hready,    // Ready in.
  input wire logic [31:0]        hwdata,    // Write data.
  input wire logic [31:0]        hrdata,    // Read data.
  input wire logic               hreadyout, // Ready out.
  input wire logic               hresp,     // Response.
  input wire csm_pkg::csm_pins_s pins,      // Serial pins.
  input wire logic               irq        // Interrupt.
);
  logic       wr_q;
  logic       gate_q;
  logic       slow_q;
  logic [7:0] a_q;
  wire        rd_a = hsel && htrans[1] && hready && !hwrite;
  // Follows writes to the gate so reads can be judged against it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q   <= 1'b0;
      a_q    <= 8'h00;
      gate_q <= 1'b0;
      slow_q <= 1'b0;
    end
    else
    begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      a_q  <= haddr[7:0];
      if (wr_q && a_q == CSM_OFF_GATE)
        gate_q <= hwdata[0];
      // A half period above one clock only follows a nonzero rate setting.
      if (wr_q && gate_q && a_q == CSM_OFF_RATE)
        slow_q <= (hwdata[CSM_RATE_DIV +: 7] != 7'h00)
                  || (hwdata[CSM_RATE_PS +: 4] != 4'h0);
      if (wr_q && a_q == CSM_OFF_GATE && !hwdata[0])
        slow_q <= 1'b0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout)
    else $error("slave not ready");
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
  a_sck_half_rate: assert property
    (slow_q && $changed(pins.sck) |=> $stable(pins.sck))
    else $error("serial clock faster than half rate");
  a_gate_reads_zero: assert property
    (rd_a && !gate_q && haddr[7:0] != CSM_OFF_GATE |=> hrdata == 32'h0)
    else $error("read with gate off not zero");
  a_gate_irq_low: assert property (!gate_q [*3] |-> !irq)
    else $error("interrupt with gate off");
  a_stop_reads_zero: assert property
    (rd_a && haddr[7:0] == CSM_OFF_STOP |=> hrdata == 32'h0)
    else $error("stop trigger reads back set");
  a_unmapped_zero: assert property
    (rd_a && haddr[7:0] > CSM_OFF_IRQMSK |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd_a |=> $stable(hrdata))
    else $error("read data changed without read");
endmodule : csm_assertions
bind csm_channel csm_assertions i_csm_assertions (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
  .irq(irq));

/* File: csm_channel.sv */
// Master transmit serial channel with AHB-Lite register access.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module csm_channel
  import csm_pkg::*;
#(
  parameter int PS_W  = 4,  // Prescaler exponent width.
  parameter int DIV_W = 7   // Channel divider width.
)
(
  input  wire logic            hclk,      // Operation clock.
  input  wire logic            hresetn,   // Asynchronous reset, active low.
  input  wire logic            hsel,      // Slave select.
  input  wire logic [31:0]     haddr,     // Byte address.
  input  wire logic [1:0]      htrans,    // Transfer type.
  input  wire logic            hwrite,    // Write when high.
  input  wire logic [2:0]      hsize,     // Transfer size.
  input  wire logic            hready,    // Bus ready in.
  input  wire logic [31:0]     hwdata,    // Write data.
  output logic      [31:0]     hrdata,    // Read data.
  output logic                 hreadyout, // Slave ready.
  output logic                 hresp,     // Always OKAY.
  output csm_pkg::csm_pins_s   pins,      // Serial clock and data pins.
  output logic                 irq        // Channel interrupt, level.
);

  localparam int HP_W = DIV_W + 1 + (1 << PS_W) - 1;

  // Bus phase capture.
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic        acc;
  logic        wr;

  // Registers.
  logic              gate_reg;
  logic              mode_reg;
  logic [3:0]        ctrl_reg;
  logic [PS_W-1:0]   ps_reg;
  logic [DIV_W-1:0]  div_reg;
  logic [7:0]        buf_reg;
  logic              bff_reg;
  logic              en_reg;
  logic              soe_reg;
  logic              so_lvl_reg;
  logic              cko_lvl_reg;
  logic [1:0]        irq_st_reg;
  logic [1:0]        irq_msk_reg;
  logic [31:0]       rd_next;

  // Shift engine.
  csm_state_e        state_reg;
  logic [7:0]        sh_reg;
  logic [4:0]        step_reg;
  logic [HP_W-1:0]   cnt_reg;
  logic [HP_W-1:0]   hp_len;
  logic              sck_reg;
  logic              so_reg;
  logic              tick;
  logic              load;
  logic              frame_end;
  logic [4:0]        nstep;
  logic [4:0]        last_step;
  logic [3:0]        flen;
  logic              dap;
  logic              ckp;

  // Picks the bit for position i of a frame in the selected order.
  function automatic logic bit_at(input logic [7:0] d, input logic [3:0] i,
                                  input logic lsb, input logic [3:0] len);
    logic [3:0] k;
    k = lsb ? i : 4'(len - 4'h1 - i);
    return d[k[2:0]];
  endfunction : bit_at

  // Decodes a data-phase write to one register offset.
  function automatic logic wr_hit(input logic p, input logic [7:0] a,
                                  input logic [7:0] off);
    return p && (a == off);
  endfunction : wr_hit

  // Address phase acceptance; the slave never inserts wait states.
  assign acc       = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Frame configuration decoded from the control register.
  assign dap       = ctrl_reg[CSM_CTRL_DAP];
  assign ckp       = ctrl_reg[CSM_CTRL_CKP];
  assign flen      = ctrl_reg[CSM_CTRL_LEN7] ? CSM_LEN7 : CSM_LEN8;
  assign last_step = 5'({flen, 1'b0} - 5'd1);
  assign nstep     = 5'(step_reg + 5'd1);

  // Half period is (divider + 1) times two to the prescaler exponent.
  assign hp_len = HP_W'((HP_W'(div_reg) + HP_W'(1)) << ps_reg);
  assign tick   = (state_reg != CSM_IDLE) && (cnt_reg == '0);
  assign load   = en_reg && bff_reg && (state_reg == CSM_IDLE);
  assign frame_end = (state_reg == CSM_SHIFT) && tick
                     && (step_reg == last_step);
  assign wr     = wr_pend_reg && gate_reg;

  // Captures the address phase for the following data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= acc && hwrite;
      rd_pend_reg <= acc && !hwrite;
      if (acc)
        addr_reg <= haddr[7:0];
    end
  end

  // Unit clock gate is always writable.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gate_reg <= 1'b0;
    else if (wr_hit(wr_pend_reg, addr_reg, CSM_OFF_GATE))
      gate_reg <= hwdata[0];
  end

  // Configuration registers; a closed gate holds them at reset values.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg    <= 1'b0;
      ctrl_reg    <= CSM_CTRL_RST;
      ps_reg      <= '0;
      div_reg     <= '0;
      soe_reg     <= 1'b0;
      irq_msk_reg <= 2'h0;
    end
    else if (!gate_reg)
    begin
      mode_reg    <= 1'b0;
      ctrl_reg    <= CSM_CTRL_RST;
      ps_reg      <= '0;
      div_reg     <= '0;
      soe_reg     <= 1'b0;
      irq_msk_reg <= 2'h0;
    end
    else
    begin
      if (wr_hit(wr, addr_reg, CSM_OFF_MODE))
        mode_reg <= hwdata[0];
      if (wr_hit(wr, addr_reg, CSM_OFF_CTRL))
        ctrl_reg <= hwdata[3:0];
      if (wr_hit(wr, addr_reg, CSM_OFF_RATE))
      begin
        ps_reg  <= hwdata[CSM_RATE_PS +: PS_W];
        div_reg <= hwdata[CSM_RATE_DIV +: DIV_W];
      end
      if (wr_hit(wr, addr_reg, CSM_OFF_OUTEN))
        soe_reg <= hwdata[0];
      if (wr_hit(wr, addr_reg, CSM_OFF_IRQMSK))
        irq_msk_reg <= hwdata[1:0];
    end
  end

  // Start and stop triggers; the stop bit never stores, so it reads 0.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_reg <= 1'b0;
    else if (!gate_reg)
      en_reg <= 1'b0;
    else if (wr_hit(wr, addr_reg, CSM_OFF_STOP) && hwdata[0])
      en_reg <= 1'b0;
    else if (wr_hit(wr, addr_reg, CSM_OFF_START) && hwdata[0])
      en_reg <= 1'b1;
  end

  // Pin levels used while stopped, the data level also while running with output enable clear; writes while running are ignored.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      so_lvl_reg  <= CSM_LEVEL_RST[CSM_LVL_SO];
      cko_lvl_reg <= CSM_LEVEL_RST[CSM_LVL_CKO];
    end
    else if (!gate_reg)
    begin
      so_lvl_reg  <= CSM_LEVEL_RST[CSM_LVL_SO];
      cko_lvl_reg <= CSM_LEVEL_RST[CSM_LVL_CKO];
    end
    else if (wr_hit(wr, addr_reg, CSM_OFF_LEVEL) && !en_reg)
    begin
      so_lvl_reg  <= hwdata[CSM_LVL_SO];
      cko_lvl_reg <= hwdata[CSM_LVL_CKO];
    end
  end

  // Transmit buffer; a write while full replaces the pending word.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      buf_reg <= 8'h00;
      bff_reg <= 1'b0;
    end
    else if (!gate_reg)
    begin
      buf_reg <= 8'h00;
      bff_reg <= 1'b0;
    end
    else if (wr_hit(wr, addr_reg, CSM_OFF_DATA))
    begin
      buf_reg <= hwdata[7:0];
      bff_reg <= 1'b1;
    end
    else if (load)
      bff_reg <= 1'b0;
  end

  // Shift engine: lead half period when the data phase bit is set, then two half periods per bit.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= CSM_IDLE;
      sh_reg    <= 8'h00;
      step_reg  <= 5'd0;
      cnt_reg   <= '0;
      sck_reg   <= 1'b1;
      so_reg    <= 1'b1;
    end
    else if (!en_reg)
    begin
      state_reg <= CSM_IDLE;
      step_reg  <= 5'd0;
      sck_reg   <= !ckp;
    end
    else if (load)
    begin
      sh_reg   <= buf_reg;
      cnt_reg  <= HP_W'(hp_len - HP_W'(1));
      step_reg <= 5'd0;
      so_reg   <= bit_at(buf_reg, 4'h0, ctrl_reg[CSM_CTRL_LSB], flen);
      if (dap)
      begin
        state_reg <= CSM_LEAD;
        sck_reg   <= !ckp;
      end
      else
      begin
        state_reg <= CSM_SHIFT;
        sck_reg   <= ckp;
      end
    end
    else if (tick)
    begin
      cnt_reg <= HP_W'(hp_len - HP_W'(1));
      unique case (state_reg)
        CSM_LEAD:
        begin
          state_reg <= CSM_SHIFT;
          sck_reg   <= ckp;
        end
        CSM_SHIFT:
        begin
          if (step_reg == last_step)
          begin
            state_reg <= CSM_IDLE;
            sck_reg   <= !ckp;
          end
          else
          begin
            step_reg <= nstep;
            sck_reg  <= nstep[0] ? !ckp : ckp;
            if (!nstep[0] && !dap)
              so_reg <= bit_at(sh_reg, 4'(nstep[4:1]),
                               ctrl_reg[CSM_CTRL_LSB], flen);
            else if (nstep[0] && dap && (nstep != last_step))
              so_reg <= bit_at(sh_reg, 4'(nstep[4:1] + 4'h1),
                               ctrl_reg[CSM_CTRL_LSB], flen);
          end
        end
        default:
          state_reg <= CSM_IDLE;
      endcase
    end
    else if (state_reg != CSM_IDLE)
      cnt_reg <= HP_W'(cnt_reg - HP_W'(1));
    else
      sck_reg <= !ckp;
  end

  // Sticky events; a set in the cycle of the clearing read wins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_st_reg <= 2'h0;
    else if (!gate_reg)
      irq_st_reg <= 2'h0;
    else
    begin
      if (acc && !hwrite && (haddr[7:0] == CSM_OFF_IRQST))
        irq_st_reg <= 2'h0;
      if (frame_end && !mode_reg)
        irq_st_reg[CSM_IRQ_TEND] <= 1'b1;
      if (load && mode_reg)
        irq_st_reg[CSM_IRQ_BEMP] <= 1'b1;
    end
  end

  // Interrupt level from unmasked status.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_st_reg & irq_msk_reg);
  end

  // Read data mux; unmapped offsets and a closed gate read zero.
  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (haddr[7:0] == CSM_OFF_GATE)
      rd_next[0] = gate_reg;
    else if (gate_reg)
    begin
      unique case (haddr[7:0])
        CSM_OFF_MODE:   rd_next[0] = mode_reg;
        CSM_OFF_CTRL:   rd_next[3:0] = ctrl_reg;
        CSM_OFF_RATE:
        begin
          rd_next[CSM_RATE_PS +: PS_W]   = ps_reg;
          rd_next[CSM_RATE_DIV +: DIV_W] = div_reg;
        end
        CSM_OFF_DATA:   rd_next[7:0] = buf_reg;
        CSM_OFF_STAT:
        begin
          rd_next[CSM_STAT_BFF]  = bff_reg;
          rd_next[CSM_STAT_BUSY] = bff_reg || (state_reg != CSM_IDLE);
        end
        CSM_OFF_ENST:   rd_next[0] = en_reg;
        CSM_OFF_OUTEN:  rd_next[0] = soe_reg;
        CSM_OFF_LEVEL:
        begin
          rd_next[CSM_LVL_SO]  = so_lvl_reg;
          rd_next[CSM_LVL_CKO] = cko_lvl_reg;
        end
        CSM_OFF_IRQST:  rd_next[1:0] = irq_st_reg;
        CSM_OFF_IRQMSK: rd_next[1:0] = irq_msk_reg;
        default:        rd_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data is registered at the address phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (acc && !hwrite)
      hrdata <= rd_next;
  end

  // Pin drivers: engine while running (data pin only with output enable set), software levels otherwise.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pins.sck <= 1'b1;
      pins.so  <= 1'b1;
    end
    else
    begin
      pins.sck <= en_reg ? sck_reg : cko_lvl_reg;
      pins.so  <= (en_reg && soe_reg) ? so_reg : so_lvl_reg;
    end
  end

endmodule : csm_channel

/* File: csm_pkg.sv */
// Package with register map, field layout and types for the serial channel.
package csm_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] CSM_OFF_GATE   = 8'h00; // Unit clock gate.
  localparam logic [7:0] CSM_OFF_MODE   = 8'h04; // Interrupt source mode.
  localparam logic [7:0] CSM_OFF_CTRL   = 8'h08; // Phase, polarity, order.
  localparam logic [7:0] CSM_OFF_RATE   = 8'h0c; // Prescaler and divider.
  localparam logic [7:0] CSM_OFF_DATA   = 8'h10; // Transmit data buffer.
  localparam logic [7:0] CSM_OFF_STAT   = 8'h14; // Buffer full and busy.
  localparam logic [7:0] CSM_OFF_START  = 8'h18; // Start trigger.
  localparam logic [7:0] CSM_OFF_STOP   = 8'h1c; // Stop trigger.
  localparam logic [7:0] CSM_OFF_ENST   = 8'h20; // Enable status.
  localparam logic [7:0] CSM_OFF_OUTEN  = 8'h24; // Serial output enable.
  localparam logic [7:0] CSM_OFF_LEVEL  = 8'h28; // Pin levels when stopped.
  localparam logic [7:0] CSM_OFF_IRQST  = 8'h2c; // Sticky event status.
  localparam logic [7:0] CSM_OFF_IRQMSK = 8'h30; // Event mask.

  // Field positions.
  localparam int CSM_CTRL_DAP  = 0;  // Data phase select.
  localparam int CSM_CTRL_CKP  = 1;  // Clock polarity select.
  localparam int CSM_CTRL_LSB  = 2;  // 1: least significant bit first.
  localparam int CSM_CTRL_LEN7 = 3;  // 1: seven-bit frames.
  localparam int CSM_RATE_PS   = 0;  // Prescaler exponent, low bit.
  localparam int CSM_RATE_DIV  = 8;  // Channel divider, low bit.
  localparam int CSM_STAT_BFF  = 0;  // Buffer full flag.
  localparam int CSM_STAT_BUSY = 1;  // Transfer in progress.
  localparam int CSM_LVL_SO    = 0;  // Data output level bit.
  localparam int CSM_LVL_CKO   = 8;  // Clock output level bit.
  localparam int CSM_IRQ_TEND  = 0;  // Transfer end event.
  localparam int CSM_IRQ_BEMP  = 1;  // Buffer empty event.

  // Reset values and frame lengths.
  localparam logic [31:0] CSM_LEVEL_RST = 32'h0000_0101;
  localparam logic [3:0]  CSM_CTRL_RST  = 4'h0;
  localparam logic [3:0]  CSM_LEN8      = 4'h8;
  localparam logic [3:0]  CSM_LEN7      = 4'h7;

  // Shift engine states.
  typedef enum logic [2:0]
  {
    CSM_IDLE  = 3'b001,
    CSM_LEAD  = 3'b010,
    CSM_SHIFT = 3'b100
  } csm_state_e;

  // Serial pin group driven to the slave.
  typedef struct packed
  {
    logic sck;
    logic so;
  } csm_pins_s;

endpackage : csm_pkg

/* File: csm_slave_model.sv */
// Serial slave model that collects the bits sent by the channel.
`timescale 1ns/1ps
module csm_slave_model
  import csm_pkg::*;
(
  input wire logic               hclk,    // Sampling clock.
  input wire logic               hresetn, // Reset, active low.
  input wire csm_pkg::csm_pins_s pins,    // Serial pins.
  input wire logic               dap,     // Data phase in use.
  input wire logic               ckp,     // Clock polarity in use.
  input wire logic               clr,     // Clears collected bits.
  output logic [15:0]            rx_reg,  // Bits, latest in bit 0.
  output logic [4:0]             cnt_reg  // Bits received.
);
  logic sck_q;
  // Takes data on the clock edge at which the bit is settled.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_q   <= 1'b1;
      rx_reg  <= 16'h0;
      cnt_reg <= 5'h0;
    end
    else
    begin
      sck_q <= pins.sck;
      if (clr)
      begin
        rx_reg  <= 16'h0;
        cnt_reg <= 5'h0;
      end
      else if (sck_q != pins.sck
               && pins.sck == (dap ? ckp : !ckp))
      begin
        rx_reg  <= {rx_reg[14:0], pins.so};
        cnt_reg <= cnt_reg + 5'h1;
      end
    end
  end
endmodule : csm_slave_model

/* File: tb.sv */
// Testbench driving the channel registers and checking the serial pins.
`timescale 1ns/1ps
`define CHK(a,e,m) begin samples_checked++; \
  if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch %0t %s", $time, m); end end
module tb;
  import csm_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic        dap = 0, ckp = 0, clr = 0, hreadyout, hresp, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [15:0] rx;
  logic [4:0]  cnt;
  csm_pins_s   pins;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  csm_channel i_csm_channel (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .irq(irq));
  csm_slave_model i_csm_slave_model (.hclk(hclk), .hresetn(hresetn),
    .pins(pins), .dap(dap), .ckp(ckp), .clr(clr), .rx_reg(rx), .cnt_reg(cnt));
  // Clock and the hang limit.
  always #10 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task rdck(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e, "register read")
  endtask : rdck
  task wirq;
    int i;
    i = 0;
    repeat (2) @(posedge hclk);
    while (irq !== 1'b1 && i < 500)
    begin
      @(posedge hclk);
      i++;
    end
    `CHK(irq, 1'b1, "no interrupt")
  endtask : wirq
  task wait_idle;
    int i;
    i = 0;
    do
    begin
      bus(1'b0, CSM_OFF_STAT, 32'h0);
      i++;
    end
    while (rd[CSM_STAT_BUSY] !== 1'b0 && i < 300);
    `CHK(rd[CSM_STAT_BUSY], 1'b0, "frame never ended")
    repeat (2) @(posedge hclk);
  endtask : wait_idle
  task t_gate;
    bus(1'b1, CSM_OFF_CTRL, 32'hf);
    rdck(CSM_OFF_CTRL, 32'h0);
    bus(1'b1, CSM_OFF_GATE, 32'h1);
    rdck(CSM_OFF_GATE, 32'h1);
    rdck(CSM_OFF_LEVEL, CSM_LEVEL_RST);
    bus(1'b1, CSM_OFF_RATE, 32'h0);
    $display("test gate done");
  endtask : t_gate
  task t_frame(input logic d, c, l7, ls, m, input logic [7:0] v);
    logic [7:0] r;
    logic [7:0] e;
    for (int k = 0; k < 8; k++)
      r[k] = v[7 - k];
    e = ls ? r : v;
    if (l7)
      e = ls ? {1'b0, r[7:1]} : {1'b0, v[6:0]};
    dap <= d;
    ckp <= c;
    clr <= 1'b1;
    bus(1'b1, CSM_OFF_CTRL, {28'h0, l7, ls, c, d});
    // Stopped clock level must match the idle level, or a false edge shows.
    bus(1'b1, CSM_OFF_LEVEL, {23'h0, !c, 8'h01});
    bus(1'b1, CSM_OFF_MODE, 32'h0);
    bus(1'b1, CSM_OFF_IRQMSK, {31'h0, m});
    bus(1'b1, CSM_OFF_OUTEN, 32'h1);
    clr <= 1'b0;
    bus(1'b1, CSM_OFF_DATA, {24'h0, v});
    bus(1'b1, CSM_OFF_START, 32'h1);
    bus(1'b0, CSM_OFF_STAT, 32'h0);
    `CHK(rd[CSM_STAT_BUSY], 1'b1, "busy")
    wait_idle();
    `CHK(cnt, l7 ? 5'd7 : 5'd8, "bit count")
    `CHK(rx[7:0], e, "frame bits")
    `CHK(pins.sck, !c, "idle clock")
    `CHK(irq, m, "masked irq")
    rdck(CSM_OFF_IRQST, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0, "irq clear")
    bus(1'b1, CSM_OFF_STOP, 32'h1);
    bus(1'b1, CSM_OFF_OUTEN, 32'h0);
    rdck(CSM_OFF_ENST, 32'h0);
    $display("test frame done");
  endtask : t_frame
  task t_cont;
    dap <= 1'b0;
    ckp <= 1'b0;
    clr <= 1'b1;
    bus(1'b1, CSM_OFF_CTRL, 32'h0);
    bus(1'b1, CSM_OFF_LEVEL, 32'h101);
    bus(1'b1, CSM_OFF_RATE, 32'h300);
    bus(1'b1, CSM_OFF_MODE, 32'h1);
    bus(1'b1, CSM_OFF_IRQMSK, 32'h2);
    bus(1'b1, CSM_OFF_OUTEN, 32'h1);
    clr <= 1'b0;
    bus(1'b1, CSM_OFF_DATA, 32'h81);
    bus(1'b1, CSM_OFF_START, 32'h1);
    wirq();
    rdck(CSM_OFF_IRQST, 32'h2);
    bus(1'b1, CSM_OFF_DATA, 32'h42);
    bus(1'b1, CSM_OFF_DATA, 32'h99);
    bus(1'b0, CSM_OFF_STAT, 32'h0);
    `CHK(rd[CSM_STAT_BFF], 1'b1, "buffer full")
    bus(1'b1, CSM_OFF_MODE, 32'h0);
    bus(1'b1, CSM_OFF_IRQMSK, 32'h1);
    wirq();
    rdck(CSM_OFF_IRQST, 32'h1);
    wirq();
    rdck(CSM_OFF_IRQST, 32'h1);
    `CHK(rx, 16'h8199, "chained frames")
    `CHK(cnt, 5'd16, "chained count")
    bus(1'b1, CSM_OFF_STOP, 32'h1);
    bus(1'b1, CSM_OFF_OUTEN, 32'h0);
    $display("test continuous done");
  endtask : t_cont
  task t_level;
    bus(1'b1, CSM_OFF_LEVEL, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK(pins, 2'b00, "pins low")
    bus(1'b1, CSM_OFF_LEVEL, 32'h100);
    repeat (3) @(posedge hclk);
    `CHK(pins, 2'b10, "clock high")
    bus(1'b1, CSM_OFF_ENST, 32'h1);
    rdck(CSM_OFF_ENST, 32'h0);
    rdck(CSM_OFF_STOP, 32'h0);
    rdck(8'h40, 32'h0);
    bus(1'b1, CSM_OFF_GATE, 32'h0);
    bus(1'b1, CSM_OFF_MODE, 32'h1);
    rdck(CSM_OFF_LEVEL, 32'h0);
    bus(1'b1, CSM_OFF_GATE, 32'h1);
    rdck(CSM_OFF_MODE, 32'h0);
    rdck(CSM_OFF_LEVEL, CSM_LEVEL_RST);
    $display("test level done");
  endtask : t_level
  // Main sequence after the reset period.
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_gate();
    t_frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'ha5);
    t_frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h3c);
    t_frame(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h5a);
    t_frame(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h1e);
    t_cont();
    t_level();
    complete_run();
  end
endmodule : tb
